// *** verilog/pcblk_pkg.sv ***
// package for the pci-to-cardbus resource lock bridge
// shared by the bridge end, the card end and the testbench
package pcblk_pkg;
    localparam int ADDR_W      = 32;
    localparam int DATA_W      = 32;
    // locked region is an aligned 16-byte block: low four bits ignored
    localparam int LOCK_GRAN_B = 4;
    // multifunction routing code that selects the lock function
    localparam logic [3:0] MFR_SEL_LOCK = 4'h5;
    localparam logic [3:0] MFR_RESET    = 4'h0;
    localparam logic [LOCK_GRAN_B-1:0] REGION_ZERO = 4'h0;
    // card end sequencing states
    typedef enum logic [1:0] {
        PCBLK_C_IDLE,
        PCBLK_C_LOCKED,
        PCBLK_C_RELEASE
    } pcblk_card_state_t;
endpackage : pcblk_pkg

// *** verilog/pcblk_if.sv ***
// interface joining the bridge end to the card end over the card bus
// assumes a single clock and no tri-state on the simplified transaction lines
`timescale 1ns/10ps
interface pcblk_if;
    logic              req;       // downstream transaction request
    logic              ack;       // card side has completed it
    logic              we;        // write when high
    logic              locked;    // transaction belongs to locked sequence
    logic [31:0]       addr;
    logic [31:0]       wdata;
    logic [31:0]       rdata;
    logic              cblock_n;  // card lock, active low
    logic              cb_busy;   // card bus activity
    modport bridge (
        output req,
        output we,
        output locked,
        output addr,
        output wdata,
        output cblock_n,
        input  ack,
        input  rdata,
        input  cb_busy
    );
    modport card (
        input  req,
        input  we,
        input  locked,
        input  addr,
        input  wdata,
        input  cblock_n,
        output ack,
        output rdata,
        output cb_busy
    );
endinterface : pcblk_if

// *** verilog/pcblk_card.sv ***
// card-side end: a cardbus target holding a lock on one 16-byte block
// assumes the bridge end drives the card-facing signals on the same clock
`timescale 1ns/10ps
module pcblk_card
    import pcblk_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    pcblk_if.card                  cb,
    output logic                   tgt_locked,
    output logic [ADDR_W-1:0]      tgt_lock_addr,
    output logic                   tgt_wr_stb,
    output logic [ADDR_W-1:0]      tgt_wr_addr,
    output logic [DATA_W-1:0]      tgt_wr_data,
    input  wire logic [DATA_W-1:0] tgt_rd_data
);
    pcblk_card_state_t state_r;
    logic              ack_r;
    logic [DATA_W-1:0] rdata_r;
    logic              hit;

    // same 16-byte block as the lock owner's region
    assign hit = cb.addr[ADDR_W-1:LOCK_GRAN_B]
                 == tgt_lock_addr[ADDR_W-1:LOCK_GRAN_B];

    // lock follows cardbus lock signal, released after idle
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r       <= PCBLK_C_IDLE;
            tgt_lock_addr <= '0;
        end else begin
            unique case (state_r)
                PCBLK_C_IDLE: begin
                    if (!cb.cblock_n && cb.req && cb.locked) begin
                        state_r       <= PCBLK_C_LOCKED;
                        tgt_lock_addr <= {cb.addr[ADDR_W-1:LOCK_GRAN_B],
                                          REGION_ZERO};
                    end
                end
                PCBLK_C_LOCKED: begin
                    if (cb.cblock_n) begin
                        state_r <= PCBLK_C_RELEASE;
                    end
                end
                PCBLK_C_RELEASE: begin
                    state_r <= PCBLK_C_IDLE;
                end
                // unused fourth code falls back to idle
                default: begin
                    state_r <= PCBLK_C_IDLE;
                end
            endcase
        end
    end

    // one-cycle completion; foreign access to locked block waits
    always_ff @(posedge clk) begin
        if (rst) begin
            ack_r       <= 1'b0;
            rdata_r     <= '0;
            tgt_wr_stb  <= 1'b0;
            tgt_wr_addr <= '0;
            tgt_wr_data <= '0;
        end else begin
            ack_r      <= 1'b0;
            tgt_wr_stb <= 1'b0;
            if (cb.req && !ack_r &&
                (state_r != PCBLK_C_LOCKED || cb.locked || !hit)) begin
                ack_r <= 1'b1;
                if (cb.we) begin
                    tgt_wr_stb  <= 1'b1;
                    tgt_wr_addr <= cb.addr;
                    tgt_wr_data <= cb.wdata;
                end else begin
                    rdata_r <= tgt_rd_data;
                end
            end
        end
    end

    assign cb.ack     = ack_r;
    assign cb.rdata   = rdata_r;
    assign cb.cb_busy = cb.req | ack_r;
    assign tgt_locked = (state_r == PCBLK_C_LOCKED);
endmodule : pcblk_card

// *** verilog/pcblk_bridge.sv ***
// bridge end: carries primary-side lock downstream onto the card bus
// assumes primary pins arrive asynchronously; requests from local logic
// Overview of operation
// - lock input only on terminal four routing
// - lock carried downstream only, never upstream
// - lock spans consecutive transactions of one master
// - unlocked addresses still served during lock
// - master acquires lock by handshake, not grant
// - others use bus; only owner locks
// - locked region is aligned 16-byte block
// - full-lock arbiter grants only the owner; this bridge has no arbiter
// - full-lock arbiter still grants cache writeback; no arbiter here, the owner's writes to other blocks are carried as locked transactions
// - no write posting while lock held
// - card side uses cardbus lock signal
`timescale 1ns/10ps
module pcblk_bridge
    import pcblk_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [3:0]        mfr_term4_sel,
    input  wire logic              multipurpose_terminal_four,
    input  wire logic              pri_req,
    input  wire logic              pri_we,
    input  wire logic [ADDR_W-1:0] pri_addr,
    input  wire logic [DATA_W-1:0] pri_wdata,
    output logic                   pri_done,
    output logic [DATA_W-1:0]      pri_rdata,
    output logic                   post_en,
    output logic                   lock_active,
    output logic                   card_lock_seen,
    pcblk_if.bridge                cb
);
    logic              t4_s1_r;
    logic              t4_s2_r;
    logic              lock_route;
    logic              lock_r;
    logic              own_r;
    logic              cblock_r;
    logic              post_r;
    logic              busy_r;
    logic              posted_r;
    logic              req_r;
    logic              we_r;
    logic              lk_r;
    logic [ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] wdata_r;
    logic [DATA_W-1:0] rdata_r;
    logic              done_r;
    logic              pri_lock;

    // terminal four pin synchroniser
    always_ff @(posedge clk) begin
        if (rst) begin
            t4_s1_r <= 1'b1;
            t4_s2_r <= 1'b1;
        end else begin
            t4_s1_r <= multipurpose_terminal_four;
            t4_s2_r <= t4_s1_r;
        end
    end

    // lock only when routing selects it; pin is active low
    assign lock_route = (mfr_term4_sel == MFR_SEL_LOCK);
    assign pri_lock   = lock_route & ~t4_s2_r;

    // owner marks lock on first request seen with lock low
    always_ff @(posedge clk) begin
        if (rst) begin
            lock_r <= 1'b0;
            own_r  <= 1'b0;
        end else begin
            lock_r <= pri_lock;
            if (!pri_lock) begin
                own_r <= 1'b0;
            end else if (pri_req && !busy_r) begin
                own_r <= 1'b1;
            end
        end
    end

    // card lock drops only on an idle card bus after release
    always_ff @(posedge clk) begin
        if (rst) begin
            cblock_r <= 1'b0;
        end else if (own_r && pri_lock) begin
            cblock_r <= 1'b1;
        end else if (!pri_lock && !busy_r && !cb.cb_busy) begin
            cblock_r <= 1'b0;
        end
    end

    // posting off while any lock held, back on once card lock drops
    always_ff @(posedge clk) begin
        if (rst) begin
            post_r <= 1'b1;
        end else begin
            post_r <= !(pri_lock || cblock_r);
        end
    end

    // downstream transaction; posted writes complete before card ack
    always_ff @(posedge clk) begin
        if (rst) begin
            busy_r   <= 1'b0;
            posted_r <= 1'b0;
            req_r    <= 1'b0;
            we_r     <= 1'b0;
            lk_r     <= 1'b0;
            addr_r   <= '0;
            wdata_r  <= '0;
            rdata_r  <= '0;
            done_r   <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (!busy_r && pri_req && !done_r) begin
                busy_r   <= 1'b1;
                req_r    <= 1'b1;
                we_r     <= pri_we;
                lk_r     <= own_r | (pri_lock & ~busy_r);
                addr_r   <= pri_addr;
                wdata_r  <= pri_wdata;
                posted_r <= pri_we & post_r;
                done_r   <= pri_we & post_r;
            end else if (busy_r && cb.ack) begin
                busy_r  <= 1'b0;
                req_r   <= 1'b0;
                rdata_r <= cb.rdata;
                done_r  <= ~posted_r;
                posted_r <= 1'b0;
            end
        end
    end

    // card side never drives lock back toward the primary bus
    assign card_lock_seen = 1'b0;
    assign cb.req      = req_r;
    assign cb.we       = we_r;
    assign cb.locked   = lk_r & cblock_r;
    assign cb.addr     = addr_r;
    assign cb.wdata    = wdata_r;
    assign cb.cblock_n = ~cblock_r;
    assign pri_done    = done_r;
    assign pri_rdata   = rdata_r;
    assign post_en     = post_r;
    assign lock_active = cblock_r;
endmodule : pcblk_bridge

// *** testbench/pcblk_checker.sv ***
// checker on the card bus between the bridge end and the card end
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
module pcblk_checker (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        req,
    input wire logic        ack,
    input wire logic        we,
    input wire logic        locked,
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic        cblock_n,
    input wire logic        cb_busy
);
    default clocking dck @(posedge clk);
    endclocking
    default disable iff (rst);
    // a taken request: ack on the next cycle, for one cycle
    sequence s_served;
        ##1 ack ##1 !ack;
    endsequence
    // transfer pulses and qualifiers
    chk_busy_level: assert property (cb_busy == (req | ack))
        else $error("busy flag wrong");
    chk_ack_pulse: assert property (ack |=> !ack)
        else $error("ack too long");
    chk_ack_cause: assert property (ack |-> $past(req))
        else $error("ack without request");
    chk_req_holds: assert property (req && !ack |=>
        req && $stable(addr) && $stable(we) && $stable(wdata))
        else $error("request moved before ack");
    // card lock relations
    chk_locked_cbl: assert property (
        req && locked |-> !cblock_n)
        else $error("locked without card lock");
    chk_owner_served: assert property (
        $rose(req) && locked |-> s_served)
        else $error("owner not served");
    chk_open_served: assert property (
        $rose(req) && cblock_n |-> s_served)
        else $error("open access not served");
    chk_release_idle: assert property (
        $rose(cblock_n) |-> !$past(cb_busy))
        else $error("lock dropped while busy");
    chk_lock_holds: assert property (
        !cblock_n && req |=> !cblock_n)
        else $error("card lock dropped mid transfer");
endmodule : pcblk_checker

// *** testbench/pcblk_tb.sv ***
// self-checking bench: bridge end and card end joined on the card bus
// assumes the package, interface and both ends are compiled first
`timescale 1ns/10ps
module pcblk_tb;
    import pcblk_pkg::*;
    logic        clk, pri_done, post_en, lock_active, card_lock_seen;
    logic        tgt_locked, tgt_wr_stb;
    logic        rst = 1'b1, pri_req = 1'b0, pri_we = 1'b0;
    logic        multipurpose_terminal_four = 1'b1;
    logic [3:0]  mfr_term4_sel = MFR_RESET;
    logic [31:0] pri_addr = 32'h0, pri_wdata = 32'h0, tgt_rd_data = 32'h0;
    logic [31:0] pri_rdata, tgt_lock_addr, tgt_wr_addr, tgt_wr_data, a;
    logic [63:0] wq[$];
    int          error_cnt = 0, n_tests = 0, cyc = 0, seed = 39, lat, wl;
    pcblk_if cbif ();
    pcblk_bridge pcblk_bridge_i (.clk, .rst, .mfr_term4_sel,
        .multipurpose_terminal_four, .pri_req, .pri_we, .pri_addr,
        .pri_wdata, .pri_done, .pri_rdata, .post_en, .lock_active,
        .card_lock_seen, .cb(cbif));
    pcblk_card pcblk_card_i (.clk, .rst, .cb(cbif), .tgt_locked,
        .tgt_lock_addr, .tgt_wr_stb, .tgt_wr_addr, .tgt_wr_data, .tgt_rd_data);
    pcblk_checker pcblk_checker_i (.clk(clk), .rst(rst), .req(cbif.req),
        .ack(cbif.ack), .we(cbif.we), .locked(cbif.locked), .addr(cbif.addr),
        .wdata(cbif.wdata), .cblock_n(cbif.cblock_n), .cb_busy(cbif.cb_busy));
    // value compare, counted
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : cmp
    task wrap_up;
        $display("compares %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up
    // one primary transfer held until the done pulse
    task xfer(input logic w, input logic [31:0] ad, input logic [31:0] dt);
        @(negedge clk);
        pri_req = 1'b1;
        pri_we = w;
        pri_addr = ad;
        pri_wdata = dt;
        tgt_rd_data = $random(seed);
        if (w) wq.push_back({ad, dt});
        lat = 0;
        do begin
            @(posedge clk);
            #1 lat++;
        end while (pri_done !== 1'b1 && lat < 50);
        cmp(pri_done, 1'b1);
        if (!w) cmp(pri_rdata, tgt_rd_data);
        @(negedge clk);
        pri_req = 1'b0;
    endtask : xfer
    // clock, cycle ceiling, downstream write model
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (tgt_wr_stb === 1'b1) begin
            cmp(tgt_wr_addr, wq[0][63:32]);
            cmp(tgt_wr_data, wq[0][31:0]);
            void'(wq.pop_front());
        end
        if (cyc == 3000) begin
            error_cnt++;
            $display("unexpected at %0t: timeout", $time);
            wrap_up();
        end
    end
    initial begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 4; i++) begin
            xfer(i[0], $random(seed), $random(seed));
            cmp(post_en, 1'b1);
        end
        wl = lat;
        $display("test open done");
        // every routing code; only the lock code takes the pin
        for (int s = 0; s < 16; s++) begin
            mfr_term4_sel = s[3:0];
            multipurpose_terminal_four = 1'b0;
            repeat (4) @(negedge clk);
            xfer(1'b0, $random(seed), 32'h0);
            repeat (2) @(negedge clk);
            cmp(lock_active, s[3:0] == MFR_SEL_LOCK);
            cmp(post_en, s[3:0] != MFR_SEL_LOCK);
            multipurpose_terminal_four = 1'b1;
            repeat (8) @(negedge clk);
            cmp({lock_active, post_en}, 2'h1);
        end
        $display("test routing done");
        // owner holds a block, write not posted, other block still served
        // routing sweep left the last code in place: select lock again
        mfr_term4_sel = MFR_SEL_LOCK;
        // lock taken by its own handshake before any exclusive access
        multipurpose_terminal_four = 1'b0;
        repeat (4) @(negedge clk);
        a = $random(seed);
        xfer(1'b0, a, 32'h0);
        @(negedge clk);
        cmp(tgt_locked, 1'b1);
        cmp(tgt_lock_addr, {a[31:4], 4'h0});
        xfer(1'b1, {a[31:4], 4'hC}, $random(seed));
        cmp(lat > wl, 1'b1);
        xfer(1'b0, a ^ 32'h10, 32'h0);
        // writeback to another block while the lock stands
        xfer(1'b1, a ^ 32'h20, $random(seed));
        cmp(lat > wl, 1'b1);
        cmp(card_lock_seen, 1'b0);
        multipurpose_terminal_four = 1'b1;
        repeat (8) @(negedge clk);
        cmp(tgt_locked, 1'b0);
        cmp(post_en, 1'b1);
        cmp(wq.size(), 32'h0);
        $display("test locked done");
        wrap_up();
    end
endmodule : pcblk_tb
